// file: design/mdor_defs.vh
`ifndef MDOR_DEFS_VH
`define MDOR_DEFS_VH

// ==========================================================
// Register offsets
`define MDOR_ADDR_W         8
`define MDOR_OFF_OPT_A      8'h28
`define MDOR_OFF_OPT_B      8'h29
`define MDOR_OFF_OPT_C      8'h2A
`define MDOR_OFF_OPT_D      8'h2B

// ==========================================================
// Reset values
`define MDOR_RST_OPT        8'h00

// ==========================================================
// Option register a fields
`define MDOR_ACCEL_LIM_HI   7
`define MDOR_ACCEL_LIM_LO   4
`define MDOR_LOCK_THR_HI    3
`define MDOR_LOCK_THR_LO    1
`define MDOR_OPT_A_MASK     8'hFE

// ==========================================================
// Option register b fields
`define MDOR_CL_STUCK_BIT   7
`define MDOR_RAMP_HI        6
`define MDOR_RAMP_LO        4
`define MDOR_DEAD_HI        3
`define MDOR_DEAD_LO        0

// ==========================================================
// Option register c fields
`define MDOR_IND_THR_HI     7
`define MDOR_IND_THR_LO     4
`define MDOR_OL_STUCK_BIT   3
`define MDOR_VREG_BIT       2
`define MDOR_IND_RATE_HI    1
`define MDOR_IND_RATE_LO    0

// ==========================================================
// Option register d fields
`define MDOR_TACH_OL_HI     7
`define MDOR_TACH_OL_LO     6
`define MDOR_TACH_RAT_HI    5
`define MDOR_TACH_RAT_LO    4
`define MDOR_KT_HI_BIT      2
`define MDOR_KT_LO_BIT      3
`define MDOR_SPD_KIND_BIT   1
`define MDOR_CL_INHIB_BIT   0

// ==========================================================
// Decoded values and codes
`define MDOR_TACH_OL_BOTH   2'h0
`define MDOR_TACH_OL_CLOSED 2'h1
`define MDOR_TACH_OL_FIRST  2'h2
`define MDOR_TACH_OL_RSVD   2'h3
`define MDOR_TACH_1_PER_1   2'h0
`define MDOR_TACH_2_PER_3   2'h1
`define MDOR_TACH_1_PER_2   2'h2
`define MDOR_TACH_1_PER_3   2'h3
`define MDOR_RAMP_UNLIM     3'h0
`define MDOR_IND_12HZ       2'h0
`define MDOR_IND_24HZ       2'h1
`define MDOR_IND_47HZ       2'h2
`define MDOR_IND_95HZ       2'h3
`define MDOR_DEAD_UNIT_NS   40
`define MDOR_CLK_NS         25
`define MDOR_HANDOVER_TOP   4

`endif

// file: design/mdor_opt_reg.v
`include "mdor_defs.vh"

// Byte-wide option register with write mask for unused bits
module mdor_opt_reg #(
  parameter [7:0] ADDR = `MDOR_OFF_OPT_A,
  parameter [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       arst_n_i,
  // Write port
  input  wire       wr_en_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  // Stored value
  output wire [7:0] value_o
);

  reg [7:0] data_reg;

  // ==========================================================
  // Storage
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_reg <= `MDOR_RST_OPT;
    end else if (wr_en_i && (addr_i == ADDR)) begin
      data_reg <= wdata_i & MASK; // Unused bits held at zero
    end
  end

  assign value_o = data_reg;

endmodule // mdor_opt_reg

// file: design/mdor_dead_timer.v
`include "mdor_defs.vh"

// Holds both gate drives off for the programmed dead time after a
// change of requested phase state.
module mdor_dead_timer #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       arst_n_i,
  // Setting and request
  input  wire [3:0] dead_code_i,
  input  wire       hs_req_i,
  input  wire       ls_req_i,
  // Gate drives
  output reg        hs_gate_o,
  output reg        ls_gate_o
);

  localparam integer STEP_I =
    (`MDOR_DEAD_UNIT_NS + `MDOR_CLK_NS - 1) / `MDOR_CLK_NS;
  localparam [CNT_W-1:0] STEP = STEP_I[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_reg;
  reg             hs_prev_reg;
  reg             ls_prev_reg;
  wire            change;
  wire [CNT_W-1:0] load;

  assign change = (hs_req_i != hs_prev_reg) || (ls_req_i != ls_prev_reg);
  // (n + 1) units of 40 ns, rounded up to cycles
  assign load = STEP * ({{(CNT_W-4){1'b0}}, dead_code_i} + {{(CNT_W-1){1'b0}}, 1'b1});

  // ==========================================================
  // Gap counter and gated drives
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg     <= {CNT_W{1'b0}};
      hs_prev_reg <= 1'b0;
      ls_prev_reg <= 1'b0;
      hs_gate_o   <= 1'b0;
      ls_gate_o   <= 1'b0;
    end else begin
      hs_prev_reg <= hs_req_i;
      ls_prev_reg <= ls_req_i;
      if (change) begin
        cnt_reg   <= load; // Start gap on every change
        hs_gate_o <= 1'b0;
        ls_gate_o <= 1'b0;
      end else if (cnt_reg != {CNT_W{1'b0}}) begin
        cnt_reg   <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        hs_gate_o <= 1'b0;
        ls_gate_o <= 1'b0;
      end else begin
        hs_gate_o <= hs_req_i & ~ls_req_i; // Never both on
        ls_gate_o <= ls_req_i & ~hs_req_i;
      end
    end
  end

endmodule // mdor_dead_timer

// file: design/mdor_option_regs.v
`include "mdor_defs.vh"

// Operation
// - Acceleration current limit code zero disables limiting, else limit is n times 0.2 A.
// - Lock current threshold is (n + 1) times 0.4 A from the three-bit field.
// - Bit 7 of option register b enables the stuck-in-closed-loop fault.
// - Closed-loop ramp code 000 is unlimited, others select falling ramp rates.
// - Dead time between high and low gate drive is (n + 1) times 40 ns; the timer rounds each unit up to two 25 ns cycles, giving (n + 1) times 50 ns.
// - Inductive sense code zero means align-and-go, else threshold is 0.2 A times (n + 1).
// - Bit 3 of option register c enables the open-loop stuck fault.
// - Bit 2 of option register c picks 5 V when low and 3.3 V when high.
// - Inductive sense rate codes give 12, 24, 47 and 95 Hz.
// - Tach open-loop select chooses both loops, closed only, or closed plus first open loop.
// - Tach ratio gives 1 per 1, 2 per 3, 1 per 2 or 1 per 3 electrical cycles.
// - Kt window low bit picks high limit 3/2 or 2, high bit picks low limit 3/4 or 1/2.
// - Bit 1 of option register d picks analog (0) or PWM (1) speed input.
// - Bit 0 of option register d clear allows closed loop handover, set keeps open loop.
// - Handover speed is n times 0.8 Hz with top bit clear, else (n + 1) times 12.8 Hz.
module mdor_option_regs #(
  parameter DEAD_CNT_W = 8,
  parameter HOVER_W    = 5
) (
  // Clock and reset
  input  wire               clk_i,
  input  wire               arst_n_i,
  // Register access port
  input  wire               reg_wr_i,
  input  wire               reg_rd_i,
  input  wire [7:0]         reg_addr_i,
  input  wire [7:0]         reg_wdata_i,
  output reg  [7:0]         reg_rdata_o,
  output reg                reg_hit_o,
  // Handover speed field from neighbouring register
  input  wire [HOVER_W-1:0] handover_speed_i,
  // Gate drive request and result
  input  wire               hs_req_i,
  input  wire               ls_req_i,
  output wire               hs_gate_o,
  output wire               ls_gate_o,
  // Current limits in units of 0.2 A
  output reg                accel_limit_en_o,
  output reg  [4:0]         accel_limit_units_o,
  output reg  [4:0]         lock_threshold_units_o,
  // Fault enables
  output reg                closed_loop_stuck_enable_o,
  output reg                open_loop_stuck_enable_o,
  // Closed-loop ramp
  output reg                ramp_unlimited_o,
  output reg  [2:0]         closed_loop_ramp_rate_o,
  // Inductive sensing
  output reg                inductive_position_detect_o,
  output reg  [4:0]         inductive_sense_threshold_units_o,
  output reg  [1:0]         inductive_sense_rate_o,
  output reg  [6:0]         inductive_sense_hz_o,
  // Regulator
  output reg                regulator_voltage_choice_o,
  // Tach output
  output reg                tach_in_open_loop_o,
  output reg                tach_first_open_only_o,
  output reg                tach_select_reserved_o,
  output reg  [1:0]         tach_pulses_o,
  output reg  [1:0]         tach_cycles_o,
  // Motor constant window in quarters of nominal
  output reg  [3:0]         kt_high_quarters_o,
  output reg  [3:0]         kt_low_quarters_o,
  // Speed input and loop control
  output reg                speed_input_kind_o,
  output reg                closed_loop_inhibit_o,
  output reg                handover_allowed_o,
  output reg  [11:0]        handover_speed_tenths_o
);

  // Stored option bytes and read decode
  wire [7:0] opt_a;
  wire [7:0] opt_b;
  wire [7:0] opt_c;
  wire [7:0] opt_d;
  reg        hit;
  reg  [7:0] rdata_next;

  // ==========================================================
  // Option registers
  // Each register decodes its own address on the shared strobe
  mdor_opt_reg #(.ADDR(`MDOR_OFF_OPT_A), .MASK(`MDOR_OPT_A_MASK)) u_reg_a (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wr_en_i  (reg_wr_i),
    .addr_i   (reg_addr_i),
    .wdata_i  (reg_wdata_i),
    .value_o  (opt_a)
  );
  mdor_opt_reg #(.ADDR(`MDOR_OFF_OPT_B), .MASK(8'hFF)) u_reg_b (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wr_en_i  (reg_wr_i),
    .addr_i   (reg_addr_i),
    .wdata_i  (reg_wdata_i),
    .value_o  (opt_b)
  );
  mdor_opt_reg #(.ADDR(`MDOR_OFF_OPT_C), .MASK(8'hFF)) u_reg_c (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wr_en_i  (reg_wr_i),
    .addr_i   (reg_addr_i),
    .wdata_i  (reg_wdata_i),
    .value_o  (opt_c)
  );
  mdor_opt_reg #(.ADDR(`MDOR_OFF_OPT_D), .MASK(8'hFF)) u_reg_d (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wr_en_i  (reg_wr_i),
    .addr_i   (reg_addr_i),
    .wdata_i  (reg_wdata_i),
    .value_o  (opt_d)
  );

  // ==========================================================
  // Read decode
  // Unmapped addresses answer zero with hit low
  always @* begin
    hit        = 1'b1;
    rdata_next = 8'h00;
    case (reg_addr_i)
      `MDOR_OFF_OPT_A: rdata_next = opt_a;
      `MDOR_OFF_OPT_B: rdata_next = opt_b;
      `MDOR_OFF_OPT_C: rdata_next = opt_c;
      `MDOR_OFF_OPT_D: rdata_next = opt_d;
      default:         hit = 1'b0;
    endcase
  end

  // Registered read data, unmapped reads zero
  // A read beside a write returns the old value
  // Data stands until the next read strobe
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o   <= 1'b0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
      reg_hit_o   <= hit;
    end
  end

  // ==========================================================
  // Dead-time gate drive
  // Gap counted in cycles, rounded up per 40 ns unit
  // Requests are taken as synchronous to the clock
  mdor_dead_timer #(.CNT_W(DEAD_CNT_W)) u_dead (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .dead_code_i (opt_b[`MDOR_DEAD_HI:`MDOR_DEAD_LO]),
    .hs_req_i    (hs_req_i),
    .ls_req_i    (ls_req_i),
    .hs_gate_o   (hs_gate_o),
    .ls_gate_o   (ls_gate_o)
  );

  // ==========================================================
  // Current limits from option register a
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      accel_limit_en_o       <= 1'b0;
      accel_limit_units_o    <= 5'h00;
      lock_threshold_units_o <= 5'h00;
    end else begin
      // Decoded values follow a write by two edges
      // Acceleration limit: zero disables, else n x 0.2 A
      accel_limit_en_o <= |opt_a[`MDOR_ACCEL_LIM_HI:`MDOR_ACCEL_LIM_LO];
      accel_limit_units_o <= {1'b0, opt_a[`MDOR_ACCEL_LIM_HI:`MDOR_ACCEL_LIM_LO]};
      // Lock threshold (n + 1) x 0.4 A = 2(n + 1) x 0.2 A
      lock_threshold_units_o <=
        {1'b0, opt_a[`MDOR_LOCK_THR_HI:`MDOR_LOCK_THR_LO], 1'b0} + 5'h02;
    end
  end

  // ==========================================================
  // Closed-loop fault enable and ramp from option register b
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      closed_loop_stuck_enable_o <= 1'b0;
      ramp_unlimited_o           <= 1'b0;
      closed_loop_ramp_rate_o    <= 3'h0;
    end else begin
      closed_loop_stuck_enable_o <= opt_b[`MDOR_CL_STUCK_BIT];
      // Unlimited flagged apart so the ramp needs no decode
      ramp_unlimited_o <= (opt_b[`MDOR_RAMP_HI:`MDOR_RAMP_LO] == `MDOR_RAMP_UNLIM);
      closed_loop_ramp_rate_o <= opt_b[`MDOR_RAMP_HI:`MDOR_RAMP_LO];
    end
  end

  // ==========================================================
  // Inductive sensing, open-loop fault and regulator, register c
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      open_loop_stuck_enable_o          <= 1'b0;
      inductive_position_detect_o       <= 1'b0;
      inductive_sense_threshold_units_o <= 5'h00;
      inductive_sense_rate_o            <= 2'h0;
      inductive_sense_hz_o              <= 7'h00;
      regulator_voltage_choice_o        <= 1'b0;
    end else begin
      open_loop_stuck_enable_o <= opt_c[`MDOR_OL_STUCK_BIT];
      // Inductive sense: zero selects align-and-go
      inductive_position_detect_o <= |opt_c[`MDOR_IND_THR_HI:`MDOR_IND_THR_LO];
      inductive_sense_threshold_units_o <=
        {1'b0, opt_c[`MDOR_IND_THR_HI:`MDOR_IND_THR_LO]} + 5'h01;
      inductive_sense_rate_o <= opt_c[`MDOR_IND_RATE_HI:`MDOR_IND_RATE_LO];
      // Rate also given in hertz for the sense scheduler
      case (opt_c[`MDOR_IND_RATE_HI:`MDOR_IND_RATE_LO])
        `MDOR_IND_12HZ: inductive_sense_hz_o <= 7'h0C;
        `MDOR_IND_24HZ: inductive_sense_hz_o <= 7'h18;
        `MDOR_IND_47HZ: inductive_sense_hz_o <= 7'h2F;
        default:        inductive_sense_hz_o <= 7'h5F;
      endcase
      // Only two regulator levels, so one bit carries the choice
      regulator_voltage_choice_o <= opt_c[`MDOR_VREG_BIT];
    end
  end

  // ==========================================================
  // Tach, motor constant window and loop control, register d
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tach_in_open_loop_o    <= 1'b0;
      tach_first_open_only_o <= 1'b0;
      tach_select_reserved_o <= 1'b0;
      tach_pulses_o          <= 2'h0;
      tach_cycles_o          <= 2'h0;
      kt_high_quarters_o     <= 4'h0;
      kt_low_quarters_o      <= 4'h0;
      speed_input_kind_o     <= 1'b0;
      closed_loop_inhibit_o  <= 1'b0;
      handover_allowed_o     <= 1'b0;
    end else begin
      // Tach open-loop behaviour
      // Reserved code flags itself and keeps open-loop pulses off
      case (opt_d[`MDOR_TACH_OL_HI:`MDOR_TACH_OL_LO])
        `MDOR_TACH_OL_BOTH: begin
          tach_in_open_loop_o    <= 1'b1;
          tach_first_open_only_o <= 1'b0;
          tach_select_reserved_o <= 1'b0;
        end
        `MDOR_TACH_OL_CLOSED: begin
          tach_in_open_loop_o    <= 1'b0;
          tach_first_open_only_o <= 1'b0;
          tach_select_reserved_o <= 1'b0;
        end
        `MDOR_TACH_OL_FIRST: begin
          tach_in_open_loop_o    <= 1'b0;
          tach_first_open_only_o <= 1'b1;
          tach_select_reserved_o <= 1'b0;
        end
        default: begin
          tach_in_open_loop_o    <= 1'b0;
          tach_first_open_only_o <= 1'b0;
          tach_select_reserved_o <= 1'b1;
        end
      endcase
      // Tach pulses per electrical cycles
      case (opt_d[`MDOR_TACH_RAT_HI:`MDOR_TACH_RAT_LO])
        `MDOR_TACH_1_PER_1: begin
          tach_pulses_o <= 2'h1;
          tach_cycles_o <= 2'h1;
        end
        `MDOR_TACH_2_PER_3: begin
          tach_pulses_o <= 2'h2;
          tach_cycles_o <= 2'h3;
        end
        `MDOR_TACH_1_PER_2: begin
          tach_pulses_o <= 2'h1;
          tach_cycles_o <= 2'h2;
        end
        default: begin
          tach_pulses_o <= 2'h1;
          tach_cycles_o <= 2'h3;
        end
      endcase
      // Kt window: 6/4 or 8/4 high, 3/4 or 2/4 low
      kt_high_quarters_o <= opt_d[`MDOR_KT_HI_BIT] ? 4'h8 : 4'h6;
      kt_low_quarters_o  <= opt_d[`MDOR_KT_LO_BIT] ? 4'h2 : 4'h3;
      speed_input_kind_o    <= opt_d[`MDOR_SPD_KIND_BIT];
      closed_loop_inhibit_o <= opt_d[`MDOR_CL_INHIB_BIT];
      handover_allowed_o    <= ~opt_d[`MDOR_CL_INHIB_BIT];
    end
  end

  // ==========================================================
  // Handover speed in 0.1 Hz: 8n or 128(n + 1)
  // Code comes from a neighbouring register, not kept here
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      handover_speed_tenths_o <= 12'h000;
    end else if (handover_speed_i[`MDOR_HANDOVER_TOP]) begin
      // Top code reaches 2048 tenths, hence twelve bits
      handover_speed_tenths_o <= {{1'b0, handover_speed_i[3:0]} + 5'h01, 7'h00};
    end else begin
      handover_speed_tenths_o <= {5'h00, handover_speed_i[3:0], 3'h0};
    end
  end

endmodule // mdor_option_regs

// file: sim/mdor_host_model.sv
// ==========================================================
// Host model driving the register access strobes
module mdor_host_model (
  // Clock
  input  logic       clk_i,
  // Register access strobes
  output logic       reg_wr_o,
  output logic       reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle strobes from time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One strobe cycle, then strobes drop and address and data show the inverse of the last value
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_wr_o = wr;
    reg_rd_o = ~wr;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask

  // Host keeps dead time at 360 ns or more, code 8 upward
  task automatic dead_time(input logic [3:0] n);
    wr(8'h29, {4'h0, (n < 4'h8) ? 4'h8 : n});
  endtask
endmodule // mdor_host_model

// file: sim/mdor_monitor.sv
// ==========================================================
// Port checker for the option register bank
module mdor_monitor (
  // Clock and reset
  input logic       clk_i,
  input logic       arst_n_i,
  // Register access
  input logic       reg_wr_i,
  input logic       reg_rd_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic [7:0] reg_rdata_o,
  input logic       reg_hit_o,
  // Decoded outputs
  input logic       hs_gate_o,
  input logic       ls_gate_o,
  input logic       accel_limit_en_o,
  input logic [4:0] accel_limit_units_o,
  input logic [4:0] lock_threshold_units_o,
  input logic       closed_loop_stuck_enable_o,
  input logic       ramp_unlimited_o,
  input logic       regulator_voltage_choice_o,
  input logic [1:0] inductive_sense_rate_o,
  input logic       speed_input_kind_o,
  input logic       closed_loop_inhibit_o,
  input logic       handover_allowed_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [3:0] dead_q;
  logic [5:0] gap_q;

  // Last dead code and cycles with both gates off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dead_q <= 4'h0;
      gap_q  <= 6'h3F;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h29) dead_q <= reg_wdata_i[3:0];
      if (hs_gate_o || ls_gate_o) gap_q <= 6'h00;
      else if (gap_q != 6'h3F) gap_q <= gap_q + 6'h01;
    end
  end

  // ==========================================================
  // Assertions
  accel_lim_a: assert property (reg_wr_i && reg_addr_i == 8'h28 |-> ##2
    accel_limit_en_o == (|$past(reg_wdata_i[7:4], 2)) &&
    accel_limit_units_o == {1'b0, $past(reg_wdata_i[7:4], 2)}) else $error("accel limit wrong");
  lock_thr_a: assert property (reg_wr_i && reg_addr_i == 8'h28 |-> ##2
    lock_threshold_units_o == {1'b0, $past(reg_wdata_i[3:1], 2), 1'b0} + 5'h02)
    else $error("lock threshold wrong");
  ramp_fields_a: assert property (reg_wr_i && reg_addr_i == 8'h29 |-> ##2
    closed_loop_stuck_enable_o == $past(reg_wdata_i[7], 2) &&
    ramp_unlimited_o == ($past(reg_wdata_i[6:4], 2) == 3'h0)) else $error("ramp fields wrong");
  reg_c_fields_a: assert property (reg_wr_i && reg_addr_i == 8'h2A |-> ##2
    {regulator_voltage_choice_o, inductive_sense_rate_o} == $past(reg_wdata_i[2:0], 2))
    else $error("regulator or sense rate wrong");
  loop_ctrl_a: assert property (reg_wr_i && reg_addr_i == 8'h2B |-> ##2
    {speed_input_kind_o, closed_loop_inhibit_o} == $past(reg_wdata_i[1:0], 2) &&
    handover_allowed_o != closed_loop_inhibit_o) else $error("loop control wrong");
  rd_hit_a: assert property (reg_rd_i |=> reg_hit_o ==
    ($past(reg_addr_i) >= 8'h28 && $past(reg_addr_i) <= 8'h2B)) else $error("hit flag wrong");
  unmapped_zero_a: assert property (reg_rd_i && (reg_addr_i < 8'h28 || reg_addr_i > 8'h2B)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  rd_bit0_a: assert property (reg_rd_i && reg_addr_i == 8'h28 |=> !reg_rdata_o[0])
    else $error("unused bit reads one");
  gate_excl_a: assert property (!(hs_gate_o && ls_gate_o)) else $error("both gates on");
  dead_gap_a: assert property ($rose(hs_gate_o) || $rose(ls_gate_o) |->
    gap_q >= {1'b0, dead_q, 1'b0} + 6'h02) else $error("dead time too short");

  // Main scenarios
  cov_rd: cover property (reg_rd_i && reg_addr_i == 8'h28);
  cov_miss: cover property (reg_rd_i ##1 !reg_hit_o);
  cov_gate: cover property ($rose(ls_gate_o));
endmodule // mdor_monitor

bind mdor_option_regs mdor_monitor u_mon (.clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_hit_o, .hs_gate_o, .ls_gate_o,
  .accel_limit_en_o, .accel_limit_units_o, .lock_threshold_units_o,
  .closed_loop_stuck_enable_o, .ramp_unlimited_o, .regulator_voltage_choice_o,
  .inductive_sense_rate_o, .speed_input_kind_o, .closed_loop_inhibit_o, .handover_allowed_o);

// file: sim/mdor_option_regs_bench.sv
// ==========================================================
// Testbench for the option register bank
module mdor_option_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        hs_req_i = 1'b0;
  logic        ls_req_i = 1'b0;
  logic [4:0]  handover_speed_i = 5'h00;
  wire         reg_wr_i, reg_rd_i, reg_hit_o, hs_gate_o, ls_gate_o;
  wire  [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  wire         accel_limit_en_o, closed_loop_stuck_enable_o, open_loop_stuck_enable_o;
  wire         ramp_unlimited_o, inductive_position_detect_o, regulator_voltage_choice_o;
  wire         tach_in_open_loop_o, tach_first_open_only_o, tach_select_reserved_o;
  wire         speed_input_kind_o, closed_loop_inhibit_o, handover_allowed_o;
  wire  [4:0]  accel_limit_units_o, lock_threshold_units_o, inductive_sense_threshold_units_o;
  wire  [2:0]  closed_loop_ramp_rate_o;
  wire  [1:0]  inductive_sense_rate_o, tach_pulses_o, tach_cycles_o;
  wire  [6:0]  inductive_sense_hz_o;
  wire  [3:0]  kt_high_quarters_o, kt_low_quarters_o;
  wire  [11:0] handover_speed_tenths_o;
  int          err_count = 0;
  int          samples_checked = 0;
  int          n;
  logic [8:0]  exp_q[$];
  logic        rd_pend = 1'b0;
  logic [31:0] seed_v;
  logic [7:0]  k8;
  logic [3:0]  k4;
  logic [7:0]  mirror[4];
  logic [6:0]  hz_tab[4] = '{7'h0C, 7'h18, 7'h2F, 7'h5F};
  logic [3:0]  pr_tab[4] = '{4'h5, 4'hB, 4'h6, 4'h7};

  // Clock
  always #12.5 clk_i = ~clk_i;

  mdor_option_regs DUT (.clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_hit_o, .handover_speed_i, .hs_req_i, .ls_req_i, .hs_gate_o, .ls_gate_o,
    .accel_limit_en_o, .accel_limit_units_o, .lock_threshold_units_o,
    .closed_loop_stuck_enable_o, .open_loop_stuck_enable_o, .ramp_unlimited_o,
    .closed_loop_ramp_rate_o, .inductive_position_detect_o, .inductive_sense_threshold_units_o,
    .inductive_sense_rate_o, .inductive_sense_hz_o, .regulator_voltage_choice_o,
    .tach_in_open_loop_o, .tach_first_open_only_o, .tach_select_reserved_o, .tach_pulses_o,
    .tach_cycles_o, .kt_high_quarters_o, .kt_low_quarters_o, .speed_input_kind_o,
    .closed_loop_inhibit_o, .handover_allowed_o, .handover_speed_tenths_o);

  mdor_host_model host (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Note the expected answer, then read
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // Read answers compared with the oldest note
  always @(posedge clk_i) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) chk(16'h0000, 16'hFFFF, "unexpected read");
      else chk({reg_hit_o, reg_rdata_o}, exp_q.pop_front(), "read data");
    end
    rd_pend = reg_rd_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(25 * 5000);
    err_count++;
    results();
  end

  // ==========================================================
  // Tests
  initial begin
    seed_v = $urandom(32'h75d6);
    repeat (5) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    for (int a = 8'h26; a < 8'h2D; a++) rd(a[7:0], {a >= 8'h28 && a <= 8'h2B, 8'h00});
    $display("test reset values done");
    repeat (4) begin
      for (int i = 0; i < 4; i++) begin
        k8 = $urandom;
        host.wr(8'h28 + i[7:0], k8);
        mirror[i] = (i == 0) ? (k8 & 8'hFE) : k8;
      end
      host.wr(8'h2C, k8);
      host.wr(8'h27, ~k8);
      for (int i = 0; i < 4; i++) rd(8'h28 + i[7:0], {1'b1, mirror[i]});
    end
    $display("test random readback done");
    for (int k = 0; k < 16; k++) begin
      k4 = k[3:0];
      host.wr(8'h28, {k4, k4[2:0], 1'b1});
      host.wr(8'h29, {k4[3], k4[2:0], k4});
      host.wr(8'h2A, {k4, k4});
      host.wr(8'h2B, {k4, k4});
      repeat (2) @(posedge clk_i);
      #1;
      chk({accel_limit_en_o, accel_limit_units_o}, {k4 != 0, 1'b0, k4}, "accel");
      chk(lock_threshold_units_o, 2 * (k4[2:0] + 1), "lock");
      chk({closed_loop_stuck_enable_o, ramp_unlimited_o, closed_loop_ramp_rate_o},
          {k4[3], k4[2:0] == 0, k4[2:0]}, "ramp");
      chk(inductive_position_detect_o, k4 != 0, "detect");
      if (k4 != 0) chk(inductive_sense_threshold_units_o, k4 + 1, "sense thr");
      chk({open_loop_stuck_enable_o, regulator_voltage_choice_o, inductive_sense_rate_o},
          k4, "reg c");
      chk(inductive_sense_hz_o, hz_tab[k4[1:0]], "sense hz");
      chk({tach_select_reserved_o, tach_first_open_only_o, tach_in_open_loop_o},
          {k4[3:2] == 3, k4[3:2] == 2, k4[3:2] == 0}, "tach sel");
      chk({tach_pulses_o, tach_cycles_o}, pr_tab[k4[1:0]], "tach ratio");
      chk({kt_high_quarters_o, kt_low_quarters_o},
          {k4[2] ? 4'h8 : 4'h6, k4[3] ? 4'h2 : 4'h3}, "kt");
      chk({speed_input_kind_o, closed_loop_inhibit_o, handover_allowed_o},
          {k4[1], k4[0], ~k4[0]}, "loop");
    end
    $display("test field decode done");
    for (int h = 0; h < 32; h++) begin
      handover_speed_i = h[4:0];
      repeat (2) @(posedge clk_i);
      #1;
      chk(handover_speed_tenths_o, h[4] ? (h[3:0] + 1) * 128 : h[3:0] * 8, "handover");
    end
    $display("test handover speed done");
    for (int j = 0; j < 2; j++) begin
      k4 = j ? 4'hF : 4'h8;
      host.dead_time(k4);
      hs_req_i = 1'b1;
      ls_req_i = 1'b0;
      repeat (40) @(posedge clk_i);
      #1;
      chk({hs_gate_o, ls_gate_o}, 2'b10, "high side on");
      hs_req_i = 1'b0;
      ls_req_i = 1'b1;
      n = 0;
      while (ls_gate_o !== 1'b1 && n < 100) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      chk(n >= 2 * (k4 + 1) && n <= 2 * (k4 + 1) + 2, 1'b1, "dead gap");
      ls_req_i = 1'b0;
      repeat (40) @(posedge clk_i);
      #1;
    end
    $display("test dead time done");
    chk(exp_q.size(), 0, "reads left");
    results();
  end
endmodule // mdor_option_regs_bench
